//--- adcc_pkg.sv
package adcc_pkg;
    ////////////////////////////////////////////////////////////////////////////
    // Register map: printed offsets are word indices, byte address is 4x index
    localparam logic [11:0] REG_IDX_MAIN     = 12'hf70;  // Main converter control
    localparam logic [11:0] REG_IDX_BUF      = 12'hf71;  // Buffer and reference control
    localparam int          ADDR_W           = 16;       // APB address width
    localparam logic [15:0] ADDR_MAIN        = {2'b00, REG_IDX_MAIN, 2'b00};
    localparam logic [15:0] ADDR_BUF         = {2'b00, REG_IDX_BUF, 2'b00};

    ////////////////////////////////////////////////////////////////////////////
    // Field positions of the main control register
    localparam int          MAIN_GO_BIT      = 7;        // conversion_go
    localparam int          MAIN_REFLO_BIT   = 6;        // ref_level_lo
    localparam int          MAIN_REFPIN_BIT  = 5;        // ref_pin_drive
    localparam int          MAIN_REPEAT_BIT  = 4;        // repeat_conversion
    localparam int          MAIN_CHAN_MSB    = 3;        // input_channel_sel top bit

    // Field positions of the buffer control register
    localparam int          BUF_REFHI_BIT    = 7;        // ref_level_hi
    localparam int          BUF_MODE_MSB     = 2;        // input_buffer_sel top bit

    // Reset values
    localparam logic [7:0]  MAIN_RESET       = 8'h00;
    localparam logic [7:0]  BUF_RESET        = 8'h80;

    ////////////////////////////////////////////////////////////////////////////
    // Buffer modes
    localparam logic [2:0]  MODE_SE_UNBUF    = 3'h0;
    localparam logic [2:0]  MODE_SE_BUF      = 3'h1;
    localparam logic [2:0]  MODE_DIFF_UNBUF  = 3'h4;
    localparam logic [2:0]  MODE_DIFF_BUF    = 3'h5;

    // Reference levels {ref_level_hi, ref_level_lo}
    localparam logic [1:0]  REF_EXTERNAL     = 2'h0;
    localparam logic [1:0]  REF_INT_1V0      = 2'h1;
    localparam logic [1:0]  REF_INT_2V0      = 2'h2;

    // Channel codes
    localparam logic [3:0]  CH_SE_LAST       = 4'h7;     // Last plain single-ended input
    localparam logic [3:0]  CH_GND_AMP       = 4'hc;     // Ground amplifier inputs
    localparam logic [3:0]  CH_TEMP          = 4'he;     // Temperature sensor
    localparam logic [3:0]  CH_DIFF_LAST     = 4'ha;     // Last differential pair
    localparam logic [3:0]  CH_CAL           = 4'hf;     // Offset calibration short

    ////////////////////////////////////////////////////////////////////////////
    // Timing, in system clock cycles
    localparam int          CLK_PERIOD_NS    = 100;      // 10 MHz system clock
    localparam int          FIRST_CYCLES     = 5129;     // First conversion
    localparam int          REFRESH_CYCLES   = 256;      // Continuous refresh
    localparam int          CNT_W            = 14;       // Holds twice the first length

    // Pair table for differential codes: {valid, noninverting, inverting}
    function automatic logic [6:0] adcc_diff_pair(input logic [3:0] code);
        case (code)
            4'h0:    adcc_diff_pair = {1'b1, 3'h0, 3'h1};
            4'h1:    adcc_diff_pair = {1'b1, 3'h2, 3'h3};
            4'h2:    adcc_diff_pair = {1'b1, 3'h4, 3'h5};
            4'h3:    adcc_diff_pair = {1'b1, 3'h1, 3'h0};
            4'h4:    adcc_diff_pair = {1'b1, 3'h3, 3'h2};
            4'h5:    adcc_diff_pair = {1'b1, 3'h5, 3'h4};
            4'h6:    adcc_diff_pair = {1'b1, 3'h6, 3'h5};
            4'h7:    adcc_diff_pair = {1'b1, 3'h0, 3'h2};
            4'h8:    adcc_diff_pair = {1'b1, 3'h0, 3'h3};
            4'h9:    adcc_diff_pair = {1'b1, 3'h0, 3'h4};
            4'ha:    adcc_diff_pair = {1'b1, 3'h0, 3'h5};
            default: adcc_diff_pair = 7'h00;
        endcase
    endfunction : adcc_diff_pair

    // One-hot switch vector for an input index
    function automatic logic [7:0] adcc_onehot(input logic [2:0] idx);
        adcc_onehot = 8'h01 << idx;
    endfunction : adcc_onehot
endpackage : adcc_pkg

//--- adcc_conv_timer.sv
module adcc_conv_timer
    import adcc_pkg::*;
#(
    parameter int FIRST_LEN = FIRST_CYCLES   // Length of the first conversion
)(
    input  wire logic i_clk,
    input  wire logic i_srst,
    input  wire logic i_ce,
    input  wire logic i_start,    // Start or restart pulse
    input  wire logic i_temp,     // Temperature sensor selected
    input  wire logic i_repeat,   // Continuous mode
    output logic      o_busy,     // Conversion running
    output logic      o_result    // One-cycle result pulse
);
    typedef enum logic [1:0] {ST_IDLE, ST_FIRST, ST_REPEAT} adcc_tmr_e;

    adcc_tmr_e          state_ff;       // Sequence state
    adcc_tmr_e          nxt_state;
    logic [CNT_W-1:0]   cnt_ff;         // Cycles elapsed in this phase
    logic [CNT_W-1:0]   nxt_cnt;
    logic               dbl_ff;         // Doubling latched at start
    logic               result_ff;      // Result pulse
    logic               nxt_result;

    // Phase lengths; temperature doubles both
    wire logic [CNT_W-1:0] first_len = dbl_ff ? CNT_W'(2 * FIRST_LEN) : CNT_W'(FIRST_LEN);
    wire logic [CNT_W-1:0] per_len   = dbl_ff ? CNT_W'(2 * REFRESH_CYCLES)
                                              : CNT_W'(REFRESH_CYCLES);
    wire logic             first_end = (cnt_ff == first_len - CNT_W'(1));
    wire logic             per_end   = (cnt_ff == per_len - CNT_W'(1));

    ////////////////////////////////////////////////////////////////////////////
    // Next state; a start in any state restarts counting from zero
    always_comb
    begin
        nxt_state  = state_ff;
        nxt_cnt    = cnt_ff + CNT_W'(1);
        nxt_result = 1'b0;
        case (state_ff)
            ST_IDLE:
            begin
                nxt_cnt = '0;
            end
            ST_FIRST:
            begin
                if (first_end)
                begin
                    nxt_result = 1'b1;
                    nxt_cnt    = '0;
                    nxt_state  = i_repeat ? ST_REPEAT : ST_IDLE;
                end
            end
            ST_REPEAT:
            begin
                if (per_end)
                begin
                    nxt_result = 1'b1;
                    nxt_cnt    = '0;
                    // Clearing repeat ends the run at the next refresh
                    nxt_state  = i_repeat ? ST_REPEAT : ST_IDLE;
                end
            end
            default:
            begin
                nxt_state = ST_IDLE;
                nxt_cnt   = '0;
            end
        endcase
        if (i_start)
        begin
            nxt_state  = ST_FIRST;
            nxt_cnt    = '0;
            nxt_result = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State registers, frozen while the clock enable is low
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            state_ff  <= ST_IDLE;
            cnt_ff    <= '0;
            dbl_ff    <= 1'b0;
            result_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            state_ff  <= nxt_state;
            cnt_ff    <= nxt_cnt;
            result_ff <= nxt_result;
            if (i_start)
                dbl_ff <= i_temp;
        end
    end

    assign o_busy   = (state_ff != ST_IDLE);
    assign o_result = result_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks: cycles between a start or result and the next result
    logic [CNT_W:0] gap_ff;        // Enabled cycles since start or result
    logic           was_first_ff;  // Next result closes the first phase
    always_ff @(posedge i_clk)
    begin
        if (i_srst)
        begin
            gap_ff       <= '0;
            was_first_ff <= 1'b0;
        end
        else if (i_ce)
        begin
            gap_ff       <= (i_start || nxt_result) ? '0 : gap_ff + (CNT_W+1)'(1);
            was_first_ff <= i_start ? 1'b1 : (nxt_result ? 1'b0 : was_first_ff);
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_srst);

    chk_first_len: assert property ((i_ce && nxt_result && was_first_ff) |->
        (gap_ff + (CNT_W+1)'(1)) == {1'b0, first_len})
        else $error("first result at wrong cycle");
    chk_refresh_len: assert property ((i_ce && nxt_result && !was_first_ff) |->
        (gap_ff + (CNT_W+1)'(1)) == {1'b0, per_len})
        else $error("refresh at wrong cycle");
    chk_restart_count: assert property ((i_ce && i_start) |=> (o_busy && cnt_ff == '0))
        else $error("start did not restart");
    chk_single_stop: assert property ((i_ce && nxt_result && state_ff == ST_FIRST
        && !i_repeat && !i_start) |=> !o_busy)
        else $error("single shot kept running");
    chk_temp_double: assert property ((i_ce && i_start) |=> (dbl_ff == $past(i_temp)))
        else $error("temperature doubling not latched");
endmodule : adcc_conv_timer

//--- adcc_ctrl.sv
// Overview of operation
// - Writing go bit starts conversion
// - Go write during conversion restarts it
// - Go reads busy, cleared on completion
// - Single shot: one result after 5129
// - Continuous: first 5129, then every 256
// - Temperature sensor doubles both times
// - Reference select: external, 1.0V, 2.0V
// - Reference resets to internal 2.0V
// - Reference pin driver follows enable bit
// - Single-ended codes 0-7 pick inputs
// - Code 1100 grounds, 1110 temperature
// - Differential codes 0-10 pick pairs
// - Differential code 1111 offset calibration
// - Reserved codes open every switch
// - Channel decode depends on buffer mode
// - Buffer mode codes decoded, others reserved
// - Calibration shorts differential inputs
module adcc_ctrl
    import adcc_pkg::*;
#(
    parameter int FIRST_LEN = FIRST_CYCLES   // Shorten for simulation
)(
    input  wire logic              I_CLK,
    input  wire logic              I_SRST,
    input  wire logic              I_CE,
    input  wire logic [ADDR_W-1:0] I_PADDR,
    input  wire logic              I_PSEL,
    input  wire logic              I_PENABLE,
    input  wire logic              I_PWRITE,
    input  wire logic [31:0]       I_PWDATA,
    input  wire logic [3:0]        I_PSTRB,
    output logic [31:0]            O_PRDATA,
    output logic                   O_PREADY,
    output logic                   O_PSLVERR,
    output logic [7:0]             O_POS_SW,        // Noninverting input switches
    output logic [7:0]             O_NEG_SW,        // Inverting input switches
    output logic                   O_GND_AMP_IN,    // Ground amplifier input nodes
    output logic                   O_TEMP_SW,       // Temperature sensor switch
    output logic                   O_CAL_SHORT,     // Short differential inputs
    output logic                   O_DIFF_MODE,     // Differential front end
    output logic                   O_UNITY_BUF,     // Unity-gain buffer on
    output logic                   O_REF_EXT,       // Reference from pin
    output logic                   O_REF_1V0,       // Internal 1.0 V
    output logic                   O_REF_2V0,       // Internal 2.0 V
    output logic                   O_REF_PIN_DRIVE, // Reference buffer onto pin
    output logic                   O_CONV_START,    // Sample start pulse
    output logic                   O_CONV_BUSY,     // Conversion running
    output logic                   O_RESULT_STB     // Result ready pulse
);
    ////////////////////////////////////////////////////////////////////////////
    // Register storage
    logic [7:0]  main_ff;      // Main control, go bit unused here
    logic [7:0]  buf_ff;       // Buffer and reference control
    logic        pready_ff;    // Access-phase ready
    logic [31:0] prdata_ff;    // Read data
    logic        pslverr_ff;   // Unmapped address

    // Bus decode
    wire logic hit_main  = (I_PADDR == ADDR_MAIN);
    wire logic hit_buf   = (I_PADDR == ADDR_BUF);
    wire logic setup     = I_PSEL && !I_PENABLE;
    wire logic done      = I_PSEL && I_PENABLE && pready_ff;
    wire logic wr_lane0  = done && I_PWRITE && I_PSTRB[0];
    wire logic wr_main   = wr_lane0 && hit_main;
    wire logic wr_buf    = wr_lane0 && hit_buf;

    // A go write of one starts or restarts; a zero does nothing
    wire logic go_write  = wr_main && I_PWDATA[MAIN_GO_BIT];

    // Timer state
    logic busy;
    logic result;

    ////////////////////////////////////////////////////////////////////////////
    // Field views
    wire logic [3:0] chan     = main_ff[MAIN_CHAN_MSB:0];
    wire logic [2:0] mode     = buf_ff[BUF_MODE_MSB:0];
    wire logic [1:0] ref_lvl  = {buf_ff[BUF_REFHI_BIT], main_ff[MAIN_REFLO_BIT]};
    wire logic       rep      = main_ff[MAIN_REPEAT_BIT];

    // Mode class; reserved modes are neither and open everything
    wire logic is_se   = (mode == MODE_SE_UNBUF) || (mode == MODE_SE_BUF);
    wire logic is_diff = (mode == MODE_DIFF_UNBUF) || (mode == MODE_DIFF_BUF);
    wire logic is_buf  = (mode == MODE_SE_BUF) || (mode == MODE_DIFF_BUF);

    // Single-ended decode
    wire logic se_pin  = is_se && (chan <= CH_SE_LAST);
    wire logic se_gnd  = is_se && (chan == CH_GND_AMP);
    wire logic se_temp = is_se && (chan == CH_TEMP);
    // Doubling must follow the channel written together with the go bit
    wire logic go_temp = is_se && (I_PWDATA[MAIN_CHAN_MSB:0] == CH_TEMP);

    // Differential decode
    wire logic [6:0] pair    = adcc_diff_pair(chan);
    wire logic       df_pair = is_diff && pair[6];
    wire logic       df_cal  = is_diff && (chan == CH_CAL);

    // Switch vectors; anything not decoded leaves all switches open
    wire logic [7:0] nxt_pos = se_pin  ? adcc_onehot(chan[2:0]) :
                               df_pair ? adcc_onehot(pair[5:3]) : 8'h00;
    wire logic [7:0] nxt_neg = df_pair ? adcc_onehot(pair[2:0]) : 8'h00;

    // Reference decode; code 11 enables no source
    wire logic nxt_ref_ext = (ref_lvl == REF_EXTERNAL);
    wire logic nxt_ref_1v0 = (ref_lvl == REF_INT_1V0);
    wire logic nxt_ref_2v0 = (ref_lvl == REF_INT_2V0);

    // Read mux; go bit shows the running conversion
    wire logic [7:0] rd_main = {busy, main_ff[6:0]};
    wire logic [31:0] nxt_prdata = hit_main ? {24'h000000, rd_main} :
                                   hit_buf  ? {24'h000000, buf_ff}  : 32'h00000000;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencing
    adcc_conv_timer #(
        .FIRST_LEN (FIRST_LEN)
    ) u_timer (
        .i_clk    (I_CLK),
        .i_srst   (I_SRST),
        .i_ce     (I_CE),
        .i_start  (go_write),
        .i_temp   (go_temp),
        .i_repeat (rep),
        .o_busy   (busy),
        .o_result (result)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Software registers; bits 6:3 of buffer stored as written
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            main_ff <= MAIN_RESET;
            buf_ff  <= BUF_RESET;
        end
        else if (I_CE)
        begin
            if (wr_main)
                main_ff <= I_PWDATA[7:0];
            if (wr_buf)
                buf_ff <= I_PWDATA[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // APB slave: ready in every access phase, data caught in setup
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            pready_ff  <= 1'b0;
            prdata_ff  <= '0;
            pslverr_ff <= 1'b0;
        end
        else if (I_CE)
        begin
            pready_ff <= setup;
            if (setup)
            begin
                prdata_ff  <= nxt_prdata;
                pslverr_ff <= !(hit_main || hit_buf);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Front-end controls, registered so the analog side sees no glitches
    always_ff @(posedge I_CLK)
    begin
        if (I_SRST)
        begin
            O_POS_SW        <= 8'h00;
            O_NEG_SW        <= 8'h00;
            O_GND_AMP_IN    <= 1'b0;
            O_TEMP_SW       <= 1'b0;
            O_CAL_SHORT     <= 1'b0;
            O_DIFF_MODE     <= 1'b0;
            O_UNITY_BUF     <= 1'b0;
            O_REF_EXT       <= 1'b0;
            O_REF_1V0       <= 1'b0;
            O_REF_2V0       <= 1'b1;
            O_REF_PIN_DRIVE <= 1'b0;
            O_CONV_START    <= 1'b0;
            O_CONV_BUSY     <= 1'b0;
            O_RESULT_STB    <= 1'b0;
        end
        else if (I_CE)
        begin
            O_POS_SW        <= nxt_pos;
            O_NEG_SW        <= nxt_neg;
            O_GND_AMP_IN    <= se_gnd;
            O_TEMP_SW       <= se_temp;
            O_CAL_SHORT     <= df_cal;
            O_DIFF_MODE     <= is_diff;
            O_UNITY_BUF     <= is_buf;
            O_REF_EXT       <= nxt_ref_ext;
            O_REF_1V0       <= nxt_ref_1v0;
            O_REF_2V0       <= nxt_ref_2v0;
            // Software keeps this low with the external reference
            O_REF_PIN_DRIVE <= main_ff[MAIN_REFPIN_BIT];
            O_CONV_START    <= go_write;
            O_CONV_BUSY     <= busy;
            O_RESULT_STB    <= result;
        end
    end

    assign O_PRDATA  = prdata_ff;
    assign O_PREADY  = pready_ff;
    assign O_PSLVERR = pslverr_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_SRST);

    sequence s_go_taken;
        I_CE && go_write;
    endsequence
    // Start pulse and busy both appear right after the go edge and hold while frozen
    sequence s_start_seen;
        busy && O_CONV_START;
    endsequence

    chk_go_start: assert property (s_go_taken |=> s_start_seen)
        else $error("go write did not start conversion");
    chk_go_zero: assert property ((I_CE && wr_main && !I_PWDATA[MAIN_GO_BIT] && !busy)
        |=> !busy)
        else $error("writing zero changed go bit");
    chk_go_reads: assert property ((I_CE && setup && hit_main) |=>
        O_PRDATA[7] == $past(busy))
        else $error("go bit does not read busy");
    chk_ref_decode: assert property (I_CE |=>
        (O_REF_2V0 == ($past(ref_lvl) == REF_INT_2V0))
        && (O_REF_1V0 == ($past(ref_lvl) == REF_INT_1V0))
        && (O_REF_EXT == ($past(ref_lvl) == REF_EXTERNAL)))
        else $error("reference decode wrong");
    chk_ref_reset: assert property (disable iff (1'b0) I_SRST |=> ref_lvl == REF_INT_2V0)
        else $error("reference not 2.0V after reset");
    chk_pin_drive: assert property (I_CE |=>
        O_REF_PIN_DRIVE == $past(main_ff[MAIN_REFPIN_BIT]))
        else $error("reference pin drive wrong");
    // Reset edge excluded: the switch outputs reset open while the registers select input 0
    chk_se_input: assert property ((I_CE && !I_SRST && is_se
        && chan <= CH_SE_LAST) |=>
        O_POS_SW == adcc_onehot($past(chan[2:0])) && O_NEG_SW == 8'h00)
        else $error("single-ended input switch wrong");
    chk_temp_gnd: assert property (I_CE |=>
        (O_TEMP_SW == $past(is_se && chan == CH_TEMP))
        && (O_GND_AMP_IN == $past(is_se && chan == CH_GND_AMP)))
        else $error("temperature or ground select wrong");
    chk_diff_pair: assert property ((I_CE && is_diff && pair[6]) |=>
        O_POS_SW == adcc_onehot($past(pair[5:3]))
        && O_NEG_SW == adcc_onehot($past(pair[2:0])))
        else $error("differential pair wrong");
    chk_cal_mode: assert property ((I_CE && is_diff && chan == CH_CAL) |=>
        O_CAL_SHORT && O_POS_SW == 8'h00 && O_NEG_SW == 8'h00)
        else $error("calibration short missing");
    chk_reserved_open: assert property ((I_CE && !se_pin && !df_pair) |=>
        O_POS_SW == 8'h00 && O_NEG_SW == 8'h00)
        else $error("reserved code left a switch closed");
endmodule : adcc_ctrl

//--- adcc_front_model.sv
module adcc_front_model
(
    input  wire logic       i_clk,     // System clock
    input  wire logic       i_start,   // Sample start pulse
    input  wire logic       i_result,  // Result strobe
    input  wire logic [7:0] i_pos,     // Noninverting switches
    input  wire logic [7:0] i_neg,     // Inverting switches
    input  wire logic       i_cal,     // Calibration short
    output int              o_results  // Results delivered
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] held_ff;  // Sampled switch image
    initial o_results = 0;
    // Sample at start; a short reads zero, so offset alone shows
    always @(posedge i_clk)
    begin
        if (i_start)
            held_ff <= i_cal ? 8'h00 : (i_pos | i_neg);
        if (i_result)
            o_results <= o_results + 1;
    end
endmodule : adcc_front_model

//--- adc_control_registers_tb_top.sv
module adc_control_registers_tb_top
    import adcc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FL = 20;  // Short first conversion keeps the run brief
    localparam logic [5:0] DP [11] = '{6'h01, 6'h13, 6'h25, 6'h08, 6'h1a, 6'h2c,
                                       6'h35, 6'h02, 6'h03, 6'h04, 6'h05};
    logic        clk = 0, srst = 1, psel = 0, pen = 0, pwr = 0, err;
    logic [15:0] paddr = 16'h0000;
    logic [31:0] pwd = 32'h0000_0000, rd, prdata;
    logic        pready, pslverr, gnd, tmp, cal, dif, uni, rx, r1, r2, rp, cst, bsy, rstb;
    logic [7:0]  pos, neg;
    int          num_errors = 0, samples_checked = 0, seed = 12, n, n0, fm_n;
    always #50 clk = ~clk;
    adcc_ctrl #(.FIRST_LEN(FL)) dut_u (.I_CLK(clk), .I_SRST(srst), .I_CE(1'b1),
        .I_PADDR(paddr), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr),
        .I_PWDATA(pwd), .I_PSTRB(4'hf), .O_PRDATA(prdata), .O_PREADY(pready),
        .O_PSLVERR(pslverr), .O_POS_SW(pos), .O_NEG_SW(neg), .O_GND_AMP_IN(gnd),
        .O_TEMP_SW(tmp), .O_CAL_SHORT(cal), .O_DIFF_MODE(dif), .O_UNITY_BUF(uni),
        .O_REF_EXT(rx), .O_REF_1V0(r1), .O_REF_2V0(r2), .O_REF_PIN_DRIVE(rp),
        .O_CONV_START(cst), .O_CONV_BUSY(bsy), .O_RESULT_STB(rstb));
    adcc_front_model fm_u (.i_clk(clk), .i_start(cst), .i_result(rstb), .i_pos(pos),
        .i_neg(neg), .i_cal(cal), .o_results(fm_n));
    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // One APB transfer; holds everything until pready is seen high at an edge
    task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pen <= 1'b0;
        pwr <= w;
        paddr <= a;
        pwd <= {24'h000000, d};
        @(posedge clk);
        pen <= 1'b1;
        // Slave outputs move only on rising edges: the low phase shows the next edge's value
        do @(negedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        pen <= 1'b0;
    endtask : apb
    // Enabled edges until the next result strobe, bounded
    task automatic meas(output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            #1;
            cnt++;
        end
        while (rstb !== 1'b1 && cnt < 1500);
    endtask : meas
    // Front-end image expected for a mode, channel, reference and pin drive
    function automatic logic [24:0] exp_fe(input logic [2:0] m, input logic [3:0] c,
                                           input logic [1:0] r, input logic p);
        logic se, df;
        logic [7:0] ps, ng;
        se = (m == 3'h0) || (m == 3'h1);
        df = (m == 3'h4) || (m == 3'h5);
        ps = (se && c <= 4'h7) ? 8'h01 << c[2:0] : (df && c <= 4'ha) ? 8'h01 << DP[c][5:3] : 8'h00;
        ng = (df && c <= 4'ha) ? 8'h01 << DP[c][2:0] : 8'h00;
        return {ps, ng, se && c == 4'hc, se && c == 4'he, df && c == 4'hf, df,
                m[0] && !m[1], r == 2'h0, r == 2'h1, r == 2'h2, p};
    endfunction : exp_fe
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_of_test
    ////////////////////////////////////////////////////////////////////////////
    // Watchdog: about eight times the expected run
    initial
    begin
        #(20000 * CLK_PERIOD_NS);
        num_errors++;
        end_of_test();
    end
    initial
    begin
        logic [1:0] r;
        logic p;
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        check(r2, 1'b1);
        apb(1'b0, ADDR_BUF, 8'h00);
        check(rd, 32'h80);
        apb(1'b0, 16'h3dc8, 8'h00);
        check(err, 1'b1);
        $display("test reset done");
        // Every mode against every channel code, random reference
        for (int m = 0; m < 8; m++)
            for (int c = 0; c < 16; c++)
            begin
                r = 2'($unsigned($random(seed)) % 3);
                p = (r != 2'h0) && ($random(seed) % 2 != 0);
                apb(1'b1, ADDR_BUF, {r[1], 4'h0, 3'(m)});
                apb(1'b1, ADDR_MAIN, {1'b0, r[0], p, 1'b0, 4'(c)});
                repeat (2) @(posedge clk);
                #1;
                check({pos, neg, gnd, tmp, cal, dif, uni, rx, r1, r2, rp},
                      exp_fe(3'(m), 4'(c), r, p));
            end
        $display("test decode done");
        // Single shot, zero write ignored, restart counted from second go
        apb(1'b1, ADDR_BUF, 8'h80);
        n0 = fm_n;
        apb(1'b1, ADDR_MAIN, 8'h80);
        apb(1'b1, ADDR_MAIN, 8'h00);
        apb(1'b0, ADDR_MAIN, 8'h00);
        check(rd[7], 1'b1);
        check(bsy, 1'b1);
        apb(1'b1, ADDR_MAIN, 8'h80);
        meas(n);
        check(n, FL + 1);
        repeat (300) @(posedge clk);
        check(fm_n, n0 + 1);
        apb(1'b0, ADDR_MAIN, 8'h00);
        check(rd[7], 1'b0);
        // Continuous on the temperature sensor, then on input 0
        apb(1'b1, ADDR_MAIN, 8'h9e);
        #1;
        check(cst, 1'b1);
        meas(n);
        check(n, 2 * FL + 1);
        meas(n);
        check(n, 2 * REFRESH_CYCLES);
        apb(1'b1, ADDR_MAIN, 8'h90);
        meas(n);
        check(n, FL + 1);
        meas(n);
        check(n, REFRESH_CYCLES);
        apb(1'b1, ADDR_MAIN, 8'h00);
        meas(n);
        apb(1'b0, ADDR_MAIN, 8'h00);
        check(rd[7], 1'b0);
        check(bsy, 1'b0);
        $display("test timing done");
        end_of_test();
    end
endmodule : adc_control_registers_tb_top
